// *** logic/asp_baud_timer.sv ***
// Eight-bit auto-reload baud counter with divide-by-two of its overflows
`timescale 1ns/1ps
module asp_baud_timer
  import asp_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic count_en,
  input wire logic [7:0] reload_val,
  input wire logic force_reload,
  output logic mid_tick,
  output logic bit_tick,
  output logic [7:0] count_val
);
  logic [7:0] cnt_ff;
  logic half_ff;
  logic [7:0] nxt_cnt;
  logic nxt_half;
  logic ovf;

  // Overflow; odd overflows mark mid-bit, even ones finish a bit
  assign ovf = count_en && (cnt_ff == COUNT_TOP) && !force_reload;
  assign mid_tick = ovf && !half_ff;
  assign bit_tick = ovf && half_ff;
  assign count_val = cnt_ff;

  // Count, reload on overflow, restart on a forced reload
  always_comb begin
    nxt_cnt = cnt_ff;
    nxt_half = half_ff;
    if (force_reload) begin
      nxt_cnt = reload_val;
      nxt_half = 1'b0;
    end else if (ovf) begin
      nxt_cnt = reload_val;
      nxt_half = !half_ff;
    end else if (count_en) begin
      nxt_cnt = cnt_ff + 8'h01;
    end
  end

  // Register counter state
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_ff <= COUNT_RST;
      half_ff <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      half_ff <= nxt_half;
    end
  end
endmodule : asp_baud_timer

// *** logic/asp_pkg.sv ***
// Shared constants and types for the asynchronous serial port
package asp_pkg;
  // Register byte offsets on the bus
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_DATA = 8'h04;
  localparam logic [7:0] ADDR_TMR = 8'h08;
  localparam logic [7:0] ADDR_RELOAD = 8'h0C;
  localparam logic [7:0] ADDR_COUNT = 8'h10;
  localparam int ADDR_LSB = 0;
  localparam int ADDR_MSB = 7;
  // Control register bit positions
  localparam int CTL_MODE9 = 7;
  localparam int CTL_ONE = 6;
  localparam int CTL_MCE = 5;
  localparam int CTL_REN = 4;
  localparam int CTL_TB8 = 3;
  localparam int CTL_RB8 = 2;
  localparam int CTL_TXDONE = 1;
  localparam int CTL_RXDONE = 0;
  // Timer control register fields
  localparam int TMR_RUN = 0;
  localparam int TMR_IE = 1;
  localparam int TMR_SEL_LSB = 2;
  localparam int TMR_SEL_MSB = 4;
  // Reset values and counter top
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] RELOAD_RST = 8'h00;
  localparam logic [7:0] COUNT_RST = 8'h00;
  localparam logic [7:0] COUNT_TOP = 8'hFF;
  // Timer clock source selection
  typedef enum logic [2:0] {
    SEL_SYS = 3'b000,
    SEL_DIV4 = 3'b001,
    SEL_DIV12 = 3'b010,
    SEL_DIV48 = 3'b011,
    SEL_EXTOSC8 = 3'b100,
    SEL_EXTIN = 3'b101
  } asp_clksel_t;
  // Prescaler counts
  localparam logic [5:0] PRE_LAST = 6'h2F;
  localparam logic [5:0] DIV12_LAST = 6'h0B;
  localparam logic [5:0] DIV12_MOD = 6'h0C;
  localparam logic [1:0] DIV4_LAST = 2'h3;
  localparam logic [2:0] EXT8_LAST = 3'h7;
  // Frame sizes
  localparam logic [3:0] FRAME8_BITS = 4'hA;
  localparam logic [3:0] FRAME9_BITS = 4'hB;
  localparam logic [2:0] DATA_LAST = 3'h7;
  // Receiver states
  typedef enum logic [2:0] {
    RX_IDLE = 3'b000,
    RX_START = 3'b001,
    RX_DATA = 3'b010,
    RX_NINTH = 3'b011,
    RX_STOP = 3'b100
  } asp_rx_state_t;
endpackage : asp_pkg

// *** logic/asp_sync.sv ***
// Two-flop synchroniser for one asynchronous input
`timescale 1ns/1ps
module asp_sync (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic async_in,
  output logic sync_out
);
  logic meta_ff;
  logic nxt_meta;
  logic nxt_sync;

  // Next values of the two stages
  always_comb begin
    nxt_meta = async_in;
    nxt_sync = meta_ff;
  end

  // Register both stages; reset to the idle-high line level so no false edge follows
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      meta_ff <= 1'b1;
      sync_out <= 1'b1;
    end else begin
      meta_ff <= nxt_meta;
      sync_out <= nxt_sync;
    end
  end
endmodule : asp_sync

// *** logic/asp_top.sv ***
// Asynchronous serial port with enhanced baud generator, AHB-Lite registers
// How it works
// - Transmitter and receiver run independently and at the same time.
// - Received byte moves to a buffer so the next byte can arrive.
// - Writes to the data buffer address load the transmit shift register only when no frame is in progress.
// - Reads of the data buffer return received data; transmit data is unreadable.
// - Interrupt raised when enabled and either done flag is set.
// - Done flags stay set until software writes them.
// - Baud timing comes from an 8-bit auto-reload timer.
// - Transmit bit clock comes from low counter overflows.
// - Receive bit clock comes from a hidden copy of the low counter.
// - Both counters' overflows are divided by two.
// - Shadow counter counts with the timer and shares the reload byte.
// - A start edge on the receive pin forces a shadow counter reload.
// - Timer clock: system, /4, /12, /48, external osc /8, external input.
// - Overflow rate is timer clock over 256 minus reload; bit rate half.
// - 8-bit frame: start, eight data bits LSB first, stop.
// - 9-bit frame adds ninth bit from control; received ninth bit stored.
// - Transmit done flag sets at the start of the stop bit.
// - Receive loads only if flag clear and, if checking, checked bit is 1.
`timescale 1ns/1ps
module asp_top
  import asp_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic rx_pin,
  output logic tx_pin,
  input wire logic ext_osc_pin,
  input wire logic timer_ext_input,
  output logic irq
);
  import asp_pkg::*;

  // Bus and register state
  logic dp_valid_ff, nxt_dp_valid;
  logic dp_write_ff, nxt_dp_write;
  logic [7:0] dp_addr_ff, nxt_dp_addr;
  logic [7:0] ctrl_ff, nxt_ctrl;
  logic [4:0] tmr_ff, nxt_tmr;
  logic [7:0] timer_reload_byte_ff, nxt_reload;
  logic [7:0] rx_buf_ff, nxt_rx_buf;
  // Transmit state
  logic [10:0] tx_sh_ff, nxt_tx_sh;
  logic [3:0] tx_left_ff, nxt_tx_left;
  logic tx_pin_ff, nxt_tx_pin;
  // Receive state
  asp_rx_state_t rx_st_ff, nxt_rx_st;
  logic [7:0] rx_sh_ff, nxt_rx_sh;
  logic [2:0] rx_cnt_ff, nxt_rx_cnt;
  logic rx_ninth_ff, nxt_rx_ninth;
  logic rx_prev_ff;
  // Prescaler state
  logic [5:0] pre_ff, nxt_pre;
  logic [2:0] ext8_ff, nxt_ext8;
  logic osc_prev_ff, tin_prev_ff;

  logic rx_s, osc_s, tin_s;
  logic wr_ctrl, wr_data, wr_tmr, wr_reload;
  logic timer_tick, start_edge;
  logic tx_mid, tx_bit, rx_mid, rx_bit;
  logic [7:0] timer_low_counter;
  logic set_tx_done, set_rx_done;
  logic osc_rise, tin_rise;
  logic [2:0] clk_sel;
  logic [5:0] pre_mod12;

  // Pin synchronisers
  asp_sync u_sync_rx (.hclk(hclk), .hresetn(hresetn), .async_in(rx_pin),
    .sync_out(rx_s));
  asp_sync u_sync_osc (.hclk(hclk), .hresetn(hresetn), .async_in(ext_osc_pin),
    .sync_out(osc_s));
  asp_sync u_sync_tin (.hclk(hclk), .hresetn(hresetn), .async_in(timer_ext_input),
    .sync_out(tin_s));

  // Bus decode of the captured data phase
  assign wr_ctrl = dp_valid_ff && dp_write_ff && (dp_addr_ff == ADDR_CTRL);
  assign wr_data = dp_valid_ff && dp_write_ff && (dp_addr_ff == ADDR_DATA);
  assign wr_tmr = dp_valid_ff && dp_write_ff && (dp_addr_ff == ADDR_TMR);
  assign wr_reload = dp_valid_ff && dp_write_ff && (dp_addr_ff == ADDR_RELOAD);
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // Read mux; data address returns the receive buffer only
  always_comb begin
    hrdata = 32'h0000_0000;
    if (dp_valid_ff && !dp_write_ff) begin
      case (dp_addr_ff)
        ADDR_CTRL: hrdata[7:0] = ctrl_ff | (8'h01 << CTL_ONE);
        ADDR_DATA: hrdata[7:0] = rx_buf_ff;
        ADDR_TMR: hrdata[4:0] = tmr_ff;
        ADDR_RELOAD: hrdata[7:0] = timer_reload_byte_ff;
        ADDR_COUNT: hrdata[7:0] = timer_low_counter;
        default: hrdata = 32'h0000_0000;
      endcase
    end
  end

  // Interrupt from either done flag while enabled
  assign irq = tmr_ff[TMR_IE] && (ctrl_ff[CTL_TXDONE] || ctrl_ff[CTL_RXDONE]);

  // Timer clock source prescaler and external edge counters
  assign clk_sel = tmr_ff[TMR_SEL_MSB:TMR_SEL_LSB];
  assign osc_rise = osc_s && !osc_prev_ff;
  assign tin_rise = tin_s && !tin_prev_ff;
  assign pre_mod12 = pre_ff % DIV12_MOD;
  always_comb begin
    nxt_pre = (pre_ff == PRE_LAST) ? 6'h00 : pre_ff + 6'h01;
    nxt_ext8 = osc_rise ? ext8_ff + 3'h1 : ext8_ff;
    case (clk_sel)
      SEL_SYS: timer_tick = 1'b1;
      SEL_DIV4: timer_tick = (pre_ff[1:0] == DIV4_LAST);
      SEL_DIV12: timer_tick = (pre_mod12 == DIV12_LAST);
      SEL_DIV48: timer_tick = (pre_ff == PRE_LAST);
      SEL_EXTOSC8: timer_tick = osc_rise && (ext8_ff == EXT8_LAST);
      SEL_EXTIN: timer_tick = tin_rise;
      default: timer_tick = 1'b0;
    endcase
    timer_tick = timer_tick && tmr_ff[TMR_RUN];
  end

  // Transmit counter on the visible low counter
  asp_baud_timer u_tx_timer (
    .hclk(hclk), .hresetn(hresetn), .count_en(timer_tick),
    .reload_val(timer_reload_byte_ff), .force_reload(1'b0),
    .mid_tick(tx_mid), .bit_tick(tx_bit), .count_val(timer_low_counter));

  // Hidden receive shadow counter, restarted at a start edge
  asp_baud_timer u_rx_timer (
    .hclk(hclk), .hresetn(hresetn), .count_en(timer_tick),
    .reload_val(timer_reload_byte_ff), .force_reload(start_edge),
    .mid_tick(rx_mid), .bit_tick(rx_bit), .count_val());

  // Transmitter: load on data write while idle, shift one bit per transmit bit tick
  always_comb begin
    nxt_tx_sh = tx_sh_ff;
    nxt_tx_left = tx_left_ff;
    nxt_tx_pin = tx_pin_ff;
    set_tx_done = 1'b0;
    if (wr_data && (tx_left_ff == 4'h0)) begin
      if (ctrl_ff[CTL_MODE9]) begin
        nxt_tx_sh = {1'b1, ctrl_ff[CTL_TB8], hwdata[7:0], 1'b0};
        nxt_tx_left = FRAME9_BITS;
      end else begin
        nxt_tx_sh = {2'b11, hwdata[7:0], 1'b0};
        nxt_tx_left = FRAME8_BITS;
      end
    end else if (tx_bit && (tx_left_ff != 4'h0)) begin
      nxt_tx_pin = tx_sh_ff[0];
      nxt_tx_sh = {1'b1, tx_sh_ff[10:1]};
      nxt_tx_left = tx_left_ff - 4'h1;
      set_tx_done = (tx_left_ff == 4'h1);
    end
  end
  assign tx_pin = tx_pin_ff;

  // Receiver: start edge, mid-bit sampling, acceptance check
  assign start_edge = (rx_st_ff == RX_IDLE) && ctrl_ff[CTL_REN] && rx_prev_ff && !rx_s
    && tmr_ff[TMR_RUN];
  always_comb begin
    nxt_rx_st = rx_st_ff;
    nxt_rx_sh = rx_sh_ff;
    nxt_rx_cnt = rx_cnt_ff;
    nxt_rx_ninth = rx_ninth_ff;
    nxt_rx_buf = rx_buf_ff;
    set_rx_done = 1'b0;
    case (rx_st_ff)
      RX_IDLE: begin
        if (start_edge) begin
          nxt_rx_st = RX_START;
        end
      end
      RX_START: begin
        if (rx_mid) begin
          nxt_rx_st = rx_s ? RX_IDLE : RX_DATA;
          nxt_rx_cnt = 3'h0;
        end
      end
      RX_DATA: begin
        if (rx_mid) begin
          nxt_rx_sh = {rx_s, rx_sh_ff[7:1]};
          nxt_rx_cnt = rx_cnt_ff + 3'h1;
          if (rx_cnt_ff == DATA_LAST) begin
            nxt_rx_st = ctrl_ff[CTL_MODE9] ? RX_NINTH : RX_STOP;
          end
        end
      end
      RX_NINTH: begin
        if (rx_mid) begin
          nxt_rx_ninth = rx_s;
          nxt_rx_st = RX_STOP;
        end
      end
      RX_STOP: begin
        if (rx_mid) begin
          nxt_rx_st = RX_IDLE;
          if (!ctrl_ff[CTL_MODE9]) begin
            nxt_rx_ninth = rx_s;
          end
          if (!ctrl_ff[CTL_RXDONE] && (!ctrl_ff[CTL_MCE]
              || (ctrl_ff[CTL_MODE9] ? rx_ninth_ff : rx_s))) begin
            nxt_rx_buf = rx_sh_ff;
            set_rx_done = 1'b1;
          end
        end
      end
      default: nxt_rx_st = RX_IDLE;
    endcase
  end

  // Registers: software writes, hardware sets win over clears
  always_comb begin
    nxt_dp_valid = hsel && hready && htrans[1];
    nxt_dp_write = hwrite;
    nxt_dp_addr = haddr[ADDR_MSB:ADDR_LSB];
    nxt_ctrl = ctrl_ff;
    nxt_tmr = tmr_ff;
    nxt_reload = timer_reload_byte_ff;
    if (wr_ctrl) begin
      nxt_ctrl = hwdata[7:0];
      nxt_ctrl[CTL_ONE] = 1'b0;
    end
    if (wr_tmr) begin
      nxt_tmr = hwdata[4:0];
    end
    if (wr_reload) begin
      nxt_reload = hwdata[7:0];
    end
    if (set_tx_done) begin
      nxt_ctrl[CTL_TXDONE] = 1'b1;
    end
    if (set_rx_done) begin
      nxt_ctrl[CTL_RXDONE] = 1'b1;
      nxt_ctrl[CTL_RB8] = nxt_rx_ninth;
    end
  end

  // Register all state
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_valid_ff <= 1'b0;
      dp_write_ff <= 1'b0;
      dp_addr_ff <= 8'h00;
      ctrl_ff <= CTRL_RST;
      tmr_ff <= 5'h00;
      timer_reload_byte_ff <= RELOAD_RST;
      rx_buf_ff <= 8'h00;
      tx_sh_ff <= 11'h7FF;
      tx_left_ff <= 4'h0;
      tx_pin_ff <= 1'b1;
      rx_st_ff <= RX_IDLE;
      rx_sh_ff <= 8'h00;
      rx_cnt_ff <= 3'h0;
      rx_ninth_ff <= 1'b0;
      rx_prev_ff <= 1'b1;
      pre_ff <= 6'h00;
      ext8_ff <= 3'h0;
      osc_prev_ff <= 1'b1;
      tin_prev_ff <= 1'b1;
    end else begin
      dp_valid_ff <= nxt_dp_valid;
      dp_write_ff <= nxt_dp_write;
      dp_addr_ff <= nxt_dp_addr;
      ctrl_ff <= nxt_ctrl;
      tmr_ff <= nxt_tmr;
      timer_reload_byte_ff <= nxt_reload;
      rx_buf_ff <= nxt_rx_buf;
      tx_sh_ff <= nxt_tx_sh;
      tx_left_ff <= nxt_tx_left;
      tx_pin_ff <= nxt_tx_pin;
      rx_st_ff <= nxt_rx_st;
      rx_sh_ff <= nxt_rx_sh;
      rx_cnt_ff <= nxt_rx_cnt;
      rx_ninth_ff <= nxt_rx_ninth;
      rx_prev_ff <= rx_s;
      pre_ff <= nxt_pre;
      ext8_ff <= nxt_ext8;
      osc_prev_ff <= osc_s;
      tin_prev_ff <= tin_s;
    end
  end
endmodule : asp_top

// *** tb/asp_chk.sv ***
// Port-level checker for the serial port top, bound to it
`timescale 1ns/1ps
module asp_chk
  import asp_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  input wire logic tx_pin,
  input wire logic irq
);
  logic dp_ff, dw_ff, cfg_ff, tx_q_ff;
  logic [7:0] da_ff, tmr_ff, rl_ff;
  int gap_ff;
  int ovf;
  wire logic wr_dp = dp_ff && dw_ff;
  wire logic run_sys = tmr_ff[TMR_RUN] && tmr_ff[TMR_SEL_MSB:TMR_SEL_LSB] == SEL_SYS;
  assign ovf = 256 - int'(rl_ff);
  // Mirror of timer setup writes and spacing of edges on the transmit pin
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_ff <= 1'b0;
      dw_ff <= 1'b0;
      da_ff <= 8'h00;
      tmr_ff <= 8'h00;
      rl_ff <= 8'h00;
      tx_q_ff <= 1'b1;
      gap_ff <= 0;
      cfg_ff <= 1'b1;
    end else begin
      dp_ff <= hsel && hready && htrans[1];
      dw_ff <= hwrite;
      da_ff <= haddr[7:0];
      tx_q_ff <= tx_pin;
      gap_ff <= (tx_pin != tx_q_ff) ? 1 : gap_ff + 1;
      cfg_ff <= (wr_dp && (da_ff == ADDR_TMR || da_ff == ADDR_RELOAD))
        || (cfg_ff && tx_pin == tx_q_ff);
      if (wr_dp && da_ff == ADDR_TMR) tmr_ff <= hwdata[7:0];
      if (wr_dp && da_ff == ADDR_RELOAD) rl_ff <= hwdata[7:0];
    end
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  property p_bus_okay;
    hreadyout && !hresp;
  endproperty
  a_bus_okay: assert property (p_bus_okay) else $error("bus not ready or not OKAY");
  property p_data_hi;
    dp_ff && !dw_ff && da_ff == ADDR_DATA |-> hrdata[31:8] == 24'h000000;
  endproperty
  a_data_hi: assert property (p_data_hi) else $error("data read upper bits set");
  property p_irq_ie;
    irq |-> tmr_ff[TMR_IE];
  endproperty
  a_irq_ie: assert property (p_irq_ie) else $error("interrupt while disabled");
  property p_irq_hold;
    $fell(irq) |-> $past(wr_dp && (da_ff == ADDR_CTRL || da_ff == ADDR_TMR));
  endproperty
  a_irq_hold: assert property (p_irq_hold) else $error("interrupt dropped by itself");
  property p_irq_cause;
    $rose(irq) |-> $past(tmr_ff[TMR_RUN] || wr_dp);
  endproperty
  a_irq_cause: assert property (p_irq_cause) else $error("flag set with timer stopped");
  property p_tx_idle;
    $rose(hresetn) |-> tx_pin [*2];
  endproperty
  a_tx_idle: assert property (p_tx_idle) else $error("transmit line not idle high");
  property p_frozen;
    !tmr_ff[TMR_RUN] && !$past(tmr_ff[TMR_RUN]) |-> $stable(tx_pin);
  endproperty
  a_frozen: assert property (p_frozen) else $error("transmit moved with timer off");
  property p_tx_gap;
    tx_pin != tx_q_ff && !cfg_ff && run_sys |-> gap_ff >= 2 * ovf && gap_ff % ovf == 0;
  endproperty
  a_tx_gap: assert property (p_tx_gap) else $error("transmit bit length wrong");
endmodule : asp_chk

bind asp_top asp_chk u_asp_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
  .hresp(hresp), .hrdata(hrdata), .tx_pin(tx_pin), .irq(irq));

// *** tb/asp_remote.sv ***
// Behavioural remote serial device on the two pins
`timescale 1ns/1ps
module asp_remote (
  input wire logic line_in,
  output logic line_out
);
  int bit_ns = 800;
  int got_n = 0;
  logic mode9 = 1'b0;
  logic got_b9;
  logic [7:0] got_byte;
  // Idle line rests high
  initial line_out = 1'b1;
  // One frame: start, data LSB first, optional ninth bit, stop
  task automatic send(input logic [7:0] d, input logic b9, input logic stp);
    line_out <= 1'b0;
    #(bit_ns);
    for (int i = 0; i < 8; i++) begin
      line_out <= d[i];
      #(bit_ns);
    end
    if (mode9) begin
      line_out <= b9;
      #(bit_ns);
    end
    line_out <= stp;
    #(bit_ns);
    // Only a bad stop bit needs the line brought back to idle
    if (!stp) line_out <= 1'b1;
  endtask : send
  // Frame capture, sampled mid-bit
  initial begin
    forever begin
      @(negedge line_in);
      #(bit_ns / 2);
      if (!line_in) begin
        for (int i = 0; i < 8; i++) begin
          #(bit_ns);
          got_byte[i] = line_in;
        end
        if (mode9) begin
          #(bit_ns);
          got_b9 = line_in;
        end
        #(bit_ns);
        if (line_in) got_n++;
      end
    end
  end
endmodule : asp_remote

// *** tb/test_async_serial_port_baud_gen.sv ***
// Self-checking bench for the serial port top
`timescale 1ns/1ps
module test_async_serial_port_baud_gen;
  import asp_pkg::*;
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, rx_pin, tx_pin;
  logic irq;
  logic ext_osc_pin = 1'b0;
  logic timer_ext_input = 1'b0;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [5:0] ph = 6'h00;
  int fail_count = 0;
  int total_checks = 0;
  assign hready = hreadyout;
  asp_top u_asp_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .rx_pin(rx_pin), .tx_pin(tx_pin),
    .ext_osc_pin(ext_osc_pin), .timer_ext_input(timer_ext_input), .irq(irq));
  asp_remote u_asp_remote (.line_in(tx_pin), .line_out(rx_pin));
  initial begin
    hclk = 1'b0;
    forever #12.5 hclk = ~hclk;
  end
  // External sources, one rising edge every four cycles
  always @(posedge hclk) begin
    ph <= ph + 6'h01;
    ext_osc_pin <= ph[1];
    timer_ext_input <= ph[1];
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD %0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : chk
  // One single transfer; read data lands in rd
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h000000, a};
    hwrite <= w;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    htrans <= 2'b00;
    hsel <= 1'b0;
    hwdata <= d;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    rd = hrdata;
  endtask : bus
  task automatic wait_bit(input int b);
    int n;
    n = 0;
    bus(ADDR_CTRL, 1'b0, 32'h0);
    while (rd[b] !== 1'b1 && n < 600) begin
      bus(ADDR_CTRL, 1'b0, 32'h0);
      n++;
    end
    chk(rd[b], 32'h1, "flag never set");
  endtask : wait_bit
  task automatic t_reset;
    chk({30'h0, tx_pin, irq}, 32'h2, "pins after reset");
    bus(ADDR_CTRL, 1'b0, 32'h0);
    chk(rd, 32'h40, "control after reset");
    bus(8'h20, 1'b1, 32'hFF);
    bus(8'h20, 1'b0, 32'h0);
    chk(rd, 32'h0, "unmapped read");
    bus(ADDR_COUNT, 1'b1, 32'h55);
    bus(ADDR_COUNT, 1'b0, 32'h0);
    chk(rd, 32'h0, "counter not writable");
    $display("t_reset done");
  endtask : t_reset
  task automatic t_sources;
    int unsigned exp_tab [7] = '{192, 48, 16, 4, 6, 48, 0};
    logic [7:0] c1;
    logic [7:0] dlt;
    for (int s = 0; s < 7; s++) begin
      bus(ADDR_TMR, 1'b1, 32'(s * 4 + 1));
      bus(ADDR_COUNT, 1'b0, 32'h0);
      c1 = rd[7:0];
      repeat (190) @(posedge hclk);
      bus(ADDR_COUNT, 1'b0, 32'h0);
      dlt = rd[7:0] - c1;
      chk(32'(dlt + 2 - exp_tab[s] <= 4), 32'h1, "timer tick rate");
    end
    bus(ADDR_TMR, 1'b1, 32'h0);
    $display("t_sources done");
  endtask : t_sources
  task automatic tx_one(input logic [7:0] d, input logic b9);
    int n0;
    n0 = u_asp_remote.got_n;
    bus(ADDR_DATA, 1'b1, {24'h0, d});
    wait_bit(CTL_TXDONE);
    chk({31'h0, tx_pin}, 32'h1, "stop bit with done flag");
    chk({31'h0, irq}, 32'h1, "interrupt on done");
    for (int i = 0; i < 100 && u_asp_remote.got_n == n0; i++) @(posedge hclk);
    chk({24'h0, u_asp_remote.got_byte}, {24'h0, d}, "byte on wire");
    if (u_asp_remote.mode9) chk({31'h0, u_asp_remote.got_b9}, {31'h0, b9}, "ninth bit");
    bus(ADDR_CTRL, 1'b0, 32'h0);
    chk(rd[CTL_TXDONE], 32'h1, "done flag kept");
    bus(ADDR_CTRL, 1'b1, {24'h0, rd[7:2], 2'b00});
    @(posedge hclk);
    chk({31'h0, irq}, 32'h0, "flag cleared");
  endtask : tx_one
  task automatic t_tx;
    bus(ADDR_RELOAD, 1'b1, 32'hF0);
    bus(ADDR_TMR, 1'b1, 32'h3);
    bus(ADDR_CTRL, 1'b1, 32'h10);
    tx_one(8'h25, 1'b0);
    bus(ADDR_DATA, 1'b0, 32'h0);
    chk(rd, 32'h0, "transmit data not readable");
    bus(ADDR_CTRL, 1'b1, 32'h98);
    u_asp_remote.mode9 = 1'b1;
    tx_one(8'hC3, 1'b1);
    $display("t_tx done");
  endtask : t_tx
  task automatic rx_one(input logic [7:0] d, input logic b9, input logic stp,
      input logic take, input logic [7:0] ctl);
    bus(ADDR_CTRL, 1'b1, {24'h0, ctl});
    u_asp_remote.mode9 = ctl[CTL_MODE9];
    u_asp_remote.send(d, b9, stp);
    @(posedge hclk);
    bus(ADDR_CTRL, 1'b0, 32'h0);
    chk(rd[CTL_RXDONE], {31'h0, take}, "receive flag");
    if (take) begin
      chk(rd[CTL_RB8], ctl[CTL_MODE9] ? b9 : stp, "received ninth bit");
      bus(ADDR_DATA, 1'b0, 32'h0);
      chk(rd, {24'h0, d}, "received byte");
    end
  endtask : rx_one
  task automatic t_rx;
    rx_one(8'h81, 1'b0, 1'b0, 1'b1, 8'h10);
    rx_one(8'h5A, 1'b0, 1'b0, 1'b0, 8'h30);
    rx_one(8'h5A, 1'b0, 1'b1, 1'b1, 8'h30);
    rx_one(8'h11, 1'b0, 1'b1, 1'b0, 8'hB0);
    rx_one(8'h22, 1'b1, 1'b1, 1'b1, 8'hB0);
    $display("t_rx done");
  endtask : t_rx
  task automatic t_duplex;
    bus(ADDR_CTRL, 1'b1, 32'h10);
    u_asp_remote.mode9 = 1'b0;
    fork
      begin
        u_asp_remote.send(8'h3C, 1'b0, 1'b1);
        u_asp_remote.send(8'hC3, 1'b0, 1'b1);
        u_asp_remote.send(8'h77, 1'b0, 1'b1);
      end
      begin
        bus(ADDR_DATA, 1'b1, 32'h96);
        wait_bit(CTL_RXDONE);
        bus(ADDR_DATA, 1'b0, 32'h0);
        chk(rd, 32'h3C, "first byte");
        bus(ADDR_CTRL, 1'b1, 32'h10);
        wait_bit(CTL_RXDONE);
        bus(ADDR_DATA, 1'b0, 32'h0);
        chk(rd, 32'hC3, "second byte");
      end
    join
    @(posedge hclk);
    bus(ADDR_DATA, 1'b0, 32'h0);
    chk(rd, 32'hC3, "overrun byte dropped");
    chk({24'h0, u_asp_remote.got_byte}, 32'h96, "sent while receiving");
    $display("t_duplex done");
  endtask : t_duplex
  task automatic finish_test;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : finish_test
  initial begin
    #1000000;
    fail_count++;
    finish_test;
  end
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_reset;
    t_sources;
    t_tx;
    t_rx;
    t_duplex;
    finish_test;
  end
endmodule : test_async_serial_port_baud_gen
